// ### design/floppy_rate_status_regs.v
// Chosen here: the strobed register port.
`include "floppy_rate_status_map.vh"
`default_nettype none
module floppy_rate_status_regs (
  input wire clk_sys,
  input wire rst_n,
  // Host register port
  input wire [9:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output wire [7:0] regRdData,
  output wire [7:0] regRdOe_n,
  // Configuration straps
  input wire [1:0] compatView,
  input wire densityPolarity,
  // Controller side
  input wire swReset,
  input wire dmaGate,
  input wire resultPhase,
  input wire cmdDone,
  input wire [1:0] completionCode,
  input wire headAddr,
  input wire [1:0] driveNumber,
  input wire seekDoneEvent,
  input wire equipmentFaultEvent,
  // Drive cable
  input wire diskChanged,
  output wire densityOut,
  // Rate seen by the rest of the controller
  output wire [1:0] rateField
);

  // One-hot view states derived from the selector
  localparam [2:0] VIEW_FIRST = 3'h1;
  localparam [2:0] VIEW_SECOND = 3'h2;
  localparam [2:0] VIEW_THIRD = 3'h4;

  reg [1:0] rate_q; // Current rate select
  reg skipPrecomp_q; // Stored, no effect on the controller
  reg densityOut_q; // Density pin level
  reg [7:0] rdData_q; // Read data, valid the cycle after a read
  reg [7:0] rdOe_q; // Read data enables, low when driven
  reg [7:0] rdData_d; // Next read data
  reg [7:0] rdOe_d; // Next read enables
  reg [2:0] view_d; // Decoded view, one-hot
  reg [1:0] rateWr_d; // Rate value after a possible write
  reg [7:0] inputView_d; // Assembled input register byte
  reg statusTaken_d; // Status byte read this cycle

  wire highDensityFlag; // Decoded slow-rate flag
  wire densityLevel; // Decoded density pin level
  wire [1:0] rateForDecode; // Rate as it stands after this cycle
  wire [7:0] statusByte; // First result byte
  wire inputHit; // Access at the shared address
  wire dataHit; // Access at the data register

  assign inputHit = (regAddr == `FRS_ADDR_INPUT);
  assign dataHit = (regAddr == `FRS_ADDR_DATA);

  // Map the selector onto a one-hot view; the spare code falls back to the first
  always @* begin
    view_d = VIEW_FIRST;
    case (compatView)
      `FRS_VIEW_FIRST: begin
        view_d = VIEW_FIRST;
      end
      `FRS_VIEW_SECOND: begin
        view_d = VIEW_SECOND;
      end
      `FRS_VIEW_THIRD: begin
        view_d = VIEW_THIRD;
      end
      default: begin
        view_d = VIEW_FIRST;
      end
    endcase
  end

  // Rate as it will be after this cycle, so the density pin follows a write at once
  always @* begin
    rateWr_d = rate_q;
    if (regWrite && inputHit) begin
      rateWr_d = regWrData[`FRS_CFG_RATE_MSB:`FRS_CFG_RATE_LSB];
    end
  end
  assign rateForDecode = rateWr_d;

  // Rate decode for the density pin only; its flag output is left open
  rate_density_decode uDecode (
    .rateField(rateForDecode),
    .densityPolarity(densityPolarity),
    .highDensityFlag(),
    .densityLevel(densityLevel)
  );

  // Flag for the view uses the stored rate, which is what a read sees
  rate_density_decode uFlag (
    .rateField(rate_q),
    .densityPolarity(1'h0),
    .highDensityFlag(highDensityFlag),
    .densityLevel()
  );

  // Configuration register: write only, shares the address with the input view
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= `FRS_RATE_RESET;
      skipPrecomp_q <= `FRS_PRECOMP_RESET;
    end else if (regWrite && inputHit) begin
      // Writes land here, never in the input register
      rate_q <= regWrData[`FRS_CFG_RATE_MSB:`FRS_CFG_RATE_LSB];
      // Only the third view has a stored precomp bit; reserved bits are dropped
      if (view_d == VIEW_THIRD) begin
        skipPrecomp_q <= regWrData[`FRS_CFG_PRECOMP_BIT];
      end
    end
    // Software reset deliberately leaves both fields alone
  end

  // Density pin: high out of hardware reset, then tracks the rate written.
  // Soft resets are not wired here, so they cannot disturb the pin.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      densityOut_q <= `FRS_DENSITY_RESET;
    end else if (regWrite && inputHit) begin
      densityOut_q <= densityLevel;
    end
  end

  // Assemble the input register byte for the active view
  always @* begin
    inputView_d = 8'h00;
    case (view_d)
      VIEW_FIRST: begin
        // Low bits are left undriven by the enables below
        inputView_d = 8'h00;
      end
      VIEW_SECOND: begin
        inputView_d[3:0] = {1'h1, rate_q, highDensityFlag};
        inputView_d[6:3] = `FRS_SECOND_ONES;
      end
      VIEW_THIRD: begin
        inputView_d[1:0] = rate_q;
        inputView_d[`FRS_IN_THIRD_PRECOMP_BIT] = skipPrecomp_q;
        inputView_d[`FRS_IN_THIRD_DMA_BIT] = dmaGate;
        inputView_d[6:4] = `FRS_THIRD_ZEROS;
      end
      default: begin
        inputView_d = 8'h00;
      end
    endcase
    // Cable line is active low, so the bit shows its inverse in all views
    inputView_d[`FRS_IN_CHANGED_BIT] = ~diskChanged;
  end

  // Read mux; unmapped addresses answer zero, fully driven
  always @* begin
    rdData_d = 8'h00;
    rdOe_d = `FRS_OE_NONE;
    statusTaken_d = 1'h0;
    if (regRead) begin
      rdOe_d = `FRS_OE_ALL;
      if (inputHit) begin
        rdData_d = inputView_d;
        if (view_d == VIEW_FIRST) begin
          // Bits six down to zero stay floating in the first view
          rdOe_d = `FRS_OE_TOP_ONLY;
        end
      end else if (dataHit && resultPhase) begin
        // First result byte goes out through the data register
        rdData_d = statusByte;
        statusTaken_d = 1'h1;
      end
    end
  end

  // Read data and enables stand only in the cycle after the strobe
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= 8'h00;
      rdOe_q <= `FRS_OE_NONE;
    end else begin
      rdData_q <= rdData_d;
      rdOe_q <= rdOe_d;
    end
  end

  // Status byte store; sticky bits cleared when the host takes the byte
  status_byte_zero uStatus (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .swReset(swReset),
    .cmdDone(cmdDone),
    .completionCode(completionCode),
    .headAddr(headAddr),
    .driveNumber(driveNumber),
    .seekDoneEvent(seekDoneEvent),
    .equipmentFaultEvent(equipmentFaultEvent),
    .byteTaken(statusTaken_d),
    .statusByte(statusByte)
  );

  assign regRdData = rdData_q;
  assign regRdOe_n = rdOe_q;
  assign densityOut = densityOut_q;
  assign rateField = rate_q;

endmodule // floppy_rate_status_regs
`default_nettype wire

// ### design/floppy_rate_status_map.vh
`ifndef FLOPPY_RATE_STATUS_MAP_VH
`define FLOPPY_RATE_STATUS_MAP_VH
// Register addresses on the host port
`define FRS_ADDR_INPUT 10'h3F7
`define FRS_ADDR_DATA 10'h3F5
// Compatibility view selector codes
`define FRS_VIEW_FIRST 2'h0
`define FRS_VIEW_SECOND 2'h1
`define FRS_VIEW_THIRD 2'h2
// Rate field codes
`define FRS_RATE_1M 2'h3
`define FRS_RATE_500K 2'h0
`define FRS_RATE_300K 2'h1
`define FRS_RATE_250K 2'h2
// Reset values
`define FRS_RATE_RESET 2'h2
`define FRS_PRECOMP_RESET 1'h0
`define FRS_DENSITY_RESET 1'h1
// Field positions in the rate configuration write
`define FRS_CFG_RATE_LSB 0
`define FRS_CFG_RATE_MSB 1
`define FRS_CFG_PRECOMP_BIT 2
// Field positions in the input register views
`define FRS_IN_CHANGED_BIT 7
`define FRS_IN_SECOND_RATE_LSB 1
`define FRS_IN_THIRD_PRECOMP_BIT 2
`define FRS_IN_THIRD_DMA_BIT 3
// Constant fills
`define FRS_SECOND_ONES 4'hF
`define FRS_THIRD_ZEROS 3'h0
// Status byte zero fields
`define FRS_SB0_CODE_MSB 7
`define FRS_SB0_CODE_LSB 6
`define FRS_SB0_SEEK_BIT 5
`define FRS_SB0_FAULT_BIT 4
`define FRS_SB0_ZERO_BIT 3
`define FRS_SB0_HEAD_BIT 2
// Read data enable patterns (low means driven)
`define FRS_OE_ALL 8'h00
`define FRS_OE_NONE 8'hFF
`define FRS_OE_TOP_ONLY 8'h7F
`endif

// ### design/rate_density_decode.v
`include "floppy_rate_status_map.vh"
`default_nettype none
// Pure decode of the rate field into the density indications
module rate_density_decode (
  input wire [1:0] rateField,
  input wire densityPolarity,
  output wire highDensityFlag,
  output wire densityLevel
);

  // Fast rates give a low flag, slow rates a high flag
  function isSlowRate;
    input [1:0] code;
    begin
      isSlowRate = (code == `FRS_RATE_300K) || (code == `FRS_RATE_250K);
    end
  endfunction

  assign highDensityFlag = isSlowRate(rateField);
  // Same split, flipped by the polarity strap
  assign densityLevel = isSlowRate(rateField) ^ densityPolarity;

endmodule // rate_density_decode
`default_nettype wire

// ### design/status_byte_zero.v
`include "floppy_rate_status_map.vh"
`default_nettype none
// Holds the first result byte of a command
module status_byte_zero (
  input wire clk_sys,
  input wire rst_n,
  input wire swReset,
  input wire cmdDone,
  input wire [1:0] completionCode,
  input wire headAddr,
  input wire [1:0] driveNumber,
  input wire seekDoneEvent,
  input wire equipmentFaultEvent,
  input wire byteTaken,
  output wire [7:0] statusByte
);

  reg [1:0] code_q; // Completion code of last command
  reg head_q; // Head address at completion
  reg [1:0] drive_q; // Drive number at completion
  reg seekDone_q; // Sticky seek completion
  reg equipmentFault_q; // Sticky equipment fault

  // Capture on completion; sticky bits cleared by reading the byte
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= 2'h0;
      head_q <= 1'h0;
      drive_q <= 2'h0;
      seekDone_q <= 1'h0;
      equipmentFault_q <= 1'h0;
    end else if (swReset) begin
      code_q <= 2'h0;
      head_q <= 1'h0;
      drive_q <= 2'h0;
      seekDone_q <= 1'h0;
      equipmentFault_q <= 1'h0;
    end else begin
      if (cmdDone) begin
        code_q <= completionCode;
        head_q <= headAddr;
        drive_q <= driveNumber;
      end
      // Set wins over the read clear so no event is lost
      if (seekDoneEvent) begin
        seekDone_q <= 1'h1;
      end else if (byteTaken) begin
        seekDone_q <= 1'h0;
      end
      if (equipmentFaultEvent) begin
        equipmentFault_q <= 1'h1;
      end else if (byteTaken) begin
        equipmentFault_q <= 1'h0;
      end
    end
  end

  // Bit 3 is tied low
  assign statusByte = {code_q, seekDone_q, equipmentFault_q, 1'h0, head_q, drive_q};

endmodule // status_byte_zero
`default_nettype wire

// ### verif/floppy_rate_status_sva.sv
`default_nettype none
// Host port answers, rate mirror and density pin
module floppy_rate_status_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [9:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] regRdOe_n,
  input wire logic [1:0] compatView,
  input wire logic densityPolarity,
  input wire logic dmaGate,
  input wire logic diskChanged,
  input wire logic densityOut,
  input wire logic [1:0] rateField
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Decoded strobes; view code 3 behaves as the first view
  wire inRd = regRead && regAddr == 10'h3F7;
  wire cfgWr = regWrite && regAddr == 10'h3F7;
  wire firstView = compatView[1] == compatView[0];
  wire [1:0] wrRate = regWrData[1:0];
  // Cable line must be steady, as it reaches the read register with no synchroniser
  chg_bit_a: assert property (
    inRd && $stable(diskChanged) && $past(diskChanged, 2) == diskChanged
    |=> regRdData[7] == ~$past(diskChanged)) else $error("changed bit wrong");
  first_oe_a: assert property (
    inRd && firstView |=> regRdOe_n == 8'h7F && regRdData[6:0] == 7'h00)
    else $error("first view drive wrong");
  other_oe_a: assert property (
    regRead && !(inRd && firstView) |=> regRdOe_n == 8'h00) else $error("read drive wrong");
  idle_bus_a: assert property (
    !regRead |=> regRdOe_n == 8'hFF && regRdData == 8'h00) else $error("idle bus wrong");
  second_view_a: assert property (
    inRd && compatView == 2'h1 |=> regRdData[6:0] == {4'hF, rateField, ^rateField})
    else $error("second view wrong");
  third_view_a: assert property (
    inRd && compatView == 2'h2
    |=> {regRdData[6:3], regRdData[1:0]} == {3'h0, $past(dmaGate), rateField})
    else $error("third view wrong");
  rate_load_a: assert property (
    cfgWr |=> rateField == $past(wrRate)) else $error("rate not loaded");
  density_a: assert property (
    cfgWr |=> densityOut == (^rateField ^ $past(densityPolarity))) else $error("density wrong");
  cfg_hold_a: assert property (
    !cfgWr |=> $stable(rateField) && $stable(densityOut)) else $error("config moved");
  cFirst: cover property (inRd && firstView);
  cThird: cover property (inRd && compatView == 2'h2);
  cFast: cover property (cfgWr && wrRate == 2'h3);
endmodule // floppy_rate_status_sva
`default_nettype wire

// ### verif/tb_floppy_rate_status_regs.sv
`default_nettype none
module tb_floppy_rate_status_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, rdSeen = 1'b0;
  logic [9:0] regAddr = 10'h000;
  logic [7:0] regWrData = 8'h00;
  logic [1:0] compatView = 2'h0, completionCode = 2'h0, driveNumber = 2'h0;
  logic densityPolarity = 1'b0, swReset = 1'b0, dmaGate = 1'b0, resultPhase = 1'b0;
  logic cmdDone = 1'b0, headAddr = 1'b0, seekDoneEvent = 1'b0, equipmentFaultEvent = 1'b0;
  logic diskChanged = 1'b0, curPre = 1'b0, curDen = 1'b1;
  logic [1:0] curRate = 2'h2;
  wire [7:0] regRdData, regRdOe_n;
  wire densityOut;
  wire [1:0] rateField;
  int fail_count = 0, comparisons = 0;
  integer seed = 32'h98AF2D94;
  logic [15:0] expQ[$]; // Expected {data, enables} per read
  floppy_rate_status_regs DUT (.clk_sys, .rst_n, .regAddr, .regWrData, .regWrite, .regRead,
    .regRdData, .regRdOe_n, .compatView, .densityPolarity, .swReset, .dmaGate, .resultPhase,
    .cmdDone, .completionCode, .headAddr, .driveNumber, .seekDoneEvent,
    .equipmentFaultEvent, .diskChanged, .densityOut, .rateField);
  always #2.5 clk_sys = ~clk_sys;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Strobe tasks leave the strobe up so back-to-back cycles never double-assign
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    {regAddr, regWrData, regWrite, regRead} <= {a, d, 2'b10};
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    expQ.push_back(e);
    {regAddr, regWrite, regRead} <= {a, 2'b01};
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    {regWrite, regRead} <= 2'b00;
    repeat (n) @(posedge clk_sys);
  endtask
  // Pins are looked at mid-cycle, then the caller is put back on a rising edge
  task automatic chkPins(input logic [1:0] r, input logic d);
    @(negedge clk_sys);
    chk({13'h0000, rateField, densityOut}, {13'h0000, r, d});
    @(posedge clk_sys);
  endtask
  // Expected view byte and enables; view 3 reads as the first view
  function automatic logic [15:0] viewExp(input int vw, input logic [1:0] rt,
    input logic dc, input logic dma, input logic pre);
    case (vw)
      1: viewExp = {~dc, 4'hF, rt, ^rt, 8'h00};
      2: viewExp = {~dc, 3'h0, dma, pre, rt, 8'h00};
      default: viewExp = {~dc, 7'h00, 8'h7F};
    endcase
  endfunction
  // Reads answer one cycle later; compare at the falling edge when settled
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rdSeen <= 1'b0;
    else rdSeen <= regRead;
  end
  always @(negedge clk_sys) begin
    if (rdSeen) chk({regRdData, regRdOe_n}, expQ.pop_front());
  end
  // One write per view, rate and polarity, then two reads back to back
  task automatic combo(input int vw, input logic [1:0] rt, input logic pol);
    logic [31:0] v;
    v = $random(seed);
    if (vw == 2) curPre = v[0];
    {curRate, curDen} = {rt, ^rt ^ pol};
    {compatView, diskChanged, dmaGate, densityPolarity} <= {vw[1:0], v[1], v[2], pol};
    wr(10'h3F7, {5'h00, vw == 2 && v[0], rt});
    idle(2);
    rd(10'h3F7, viewExp(vw, rt, v[1], v[2], curPre));
    rd(10'h3F7, viewExp(vw, rt, v[1], v[2], curPre));
    idle(1);
    chkPins(rt, curDen);
  endtask
  // Eighteen times the expected run length means a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end
  initial begin
    int vw, rt, k;
    logic [31:0] v;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chkPins(2'h2, 1'b1);
    compatView <= 2'h2;
    idle(3);
    rd(10'h3F7, viewExp(2, 2'h2, 1'b0, 1'b0, 1'b0));
    idle(1);
    $display("test reset values done");
    for (vw = 0; vw < 4; vw++)
      for (rt = 0; rt < 4; rt++)
        for (k = 0; k < 2; k++) combo(vw, rt[1:0], k[0]);
    $display("test views done");
    v = $random(seed);
    wr(10'h3F5, 8'h01);
    wr({1'b0, v[8:0]}, 8'h03);
    rd({1'b0, v[8:0]}, 16'h0000);
    compatView <= 2'h2;
    curPre = 1'b1;
    wr(10'h3F7, {6'h01, curRate});
    swReset <= 1'b1;
    idle(1);
    swReset <= 1'b0;
    rd(10'h3F7, viewExp(2, curRate, diskChanged, dmaGate, curPre));
    idle(1);
    chkPins(curRate, curDen);
    $display("test refusals and soft reset done");
    resultPhase <= 1'b1;
    for (k = 0; k < 4; k++) begin
      v = $random(seed);
      {completionCode, headAddr, driveNumber, seekDoneEvent, equipmentFaultEvent} <=
        {k[1:0], v[0], v[2:1], v[3], v[4]};
      cmdDone <= 1'b1;
      idle(1);
      {cmdDone, seekDoneEvent, equipmentFaultEvent} <= 3'h0;
      idle(1);
      rd(10'h3F5, {k[1:0], v[3], v[4], 1'b0, v[0], v[2:1], 8'h00});
      idle(1);
      rd(10'h3F5, {k[1:0], 3'h0, v[0], v[2:1], 8'h00});
      idle(1);
    end
    {resultPhase, seekDoneEvent} <= 2'b01;
    rd(10'h3F5, 16'h0000);
    {swReset, seekDoneEvent} <= 2'b10;
    idle(1);
    {swReset, resultPhase} <= 2'b01;
    rd(10'h3F5, 16'h0000);
    idle(1);
    $display("test status byte done");
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    idle(3);
    chkPins(2'h2, 1'b1);
    rd(10'h3F7, viewExp(2, 2'h2, diskChanged, dmaGate, 1'b0));
    idle(2);
    $display("test hardware reset done");
    end_sim();
  end
endmodule // tb_floppy_rate_status_regs
bind floppy_rate_status_regs floppy_rate_status_sva chkU (.clk_sys, .rst_n, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .regRdOe_n, .compatView, .densityPolarity,
  .dmaGate, .diskChanged, .densityOut, .rateField);
`default_nettype wire
